// ---- ulsl_map.svh ----
// constants for the line status logic: bit positions, reset value, depths
// assumes inclusion by ulsl_pkg users and the top module only
`ifndef ULSL_MAP_SVH
`define ULSL_MAP_SVH
// line_status bit positions
`define ULSL_BIT_FIFO_ERR 7
`define ULSL_BIT_TX_EMPTY 6
`define ULSL_BIT_HOLD_EMPTY 5
`define ULSL_BIT_BREAK 4
`define ULSL_BIT_FRAMING 3
`define ULSL_BIT_PARITY 2
`define ULSL_BIT_OVERRUN 1
`define ULSL_BIT_DATA_READY 0
// line_status value after reset: both transmit empties set
`define ULSL_RESET_VAL 8'h60
// receive storage depth in fifo mode and in holding-register mode
`define ULSL_FIFO_DEPTH 32
`define ULSL_HOLD_DEPTH 1
`endif

// ---- ulsl_pkg.sv ----
// types shared by the line status logic and its tag fifo
// assumes nothing beyond a SystemVerilog compiler
package ulsl_pkg;
   // per-character receive error tags
   typedef struct packed {
      logic brk;
      logic frm;
      logic par;
   } ulsl_tag_t;
   // one character report from the receive sampler
   typedef struct packed {
      logic valid;   // one-cycle pulse, character complete
      logic all_low; // whole frame was zero, a break character
      logic frm;
      logic par;
   } ulsl_rx_evt_t;
   // transmit path state
   typedef struct packed {
      logic hold_write; // cpu loads holding register or fifo
      logic hold_to_shift; // character moves into shift register
      logic shift_busy; // shift register holds a character
      logic fifo_empty; // transmit fifo holds nothing
   } ulsl_tx_stat_t;
endpackage : ulsl_pkg

// ---- ulsl_tag_fifo.sv ----
// error tag store that runs alongside the receive data fifo
// assumes push and pop follow the data fifo one for one
`timescale 1ns/1ps
module ulsl_tag_fifo #(
   parameter int DEPTH = 32,
   parameter int CW = 6
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // control
   input wire logic flush_i,
   input wire logic [CW-1:0] limit_i,
   input wire logic push_i,
   input wire ulsl_pkg::ulsl_tag_t tag_i,
   input wire logic pop_i,
   // state
   output ulsl_pkg::ulsl_tag_t head_o,
   output logic empty_o,
   output logic full_o,
   output logic err_any_o
);
   import ulsl_pkg::*;
   localparam int AW = $clog2(DEPTH);

   // refuse sizes the pointers and counters cannot serve
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0
       || CW <= AW) begin : g_bad_cfg
      $error("ulsl_tag_fifo: DEPTH must be a power of two, CW > log2");
   end

   ulsl_tag_t mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [CW-1:0] count_reg;
   logic [CW-1:0] err_cnt_reg;
   logic do_push;
   logic do_pop;

   // a push into a full store is dropped, the caller reports overrun
   assign do_push = push_i && !full_o;
   assign do_pop = pop_i && !empty_o;
   assign empty_o = (count_reg == '0);
   assign full_o = (count_reg >= limit_i);
   assign head_o = mem[rd_ptr_reg];
   assign err_any_o = (err_cnt_reg != '0);

   function automatic logic tagged_err(input ulsl_tag_t t);
      return t.brk | t.frm | t.par;
   endfunction : tagged_err

   // storage array, no reset needed for the words
   always_ff @(posedge clk_sys_i) begin
      if (ce_i && do_push) begin
         mem[wr_ptr_reg] <= tag_i;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || (ce_i && flush_i)) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else if (ce_i) begin
         if (do_push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (do_pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         count_reg <= count_reg + CW'(do_push) - CW'(do_pop);
      end
   end

   // count of stored characters that carry any error tag
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i || (ce_i && flush_i)) begin
         err_cnt_reg <= '0;
      end else if (ce_i) begin
         err_cnt_reg <= err_cnt_reg
            + CW'(do_push && tagged_err(tag_i))
            - CW'(do_pop && tagged_err(head_o));
      end
   end
endmodule : ulsl_tag_fifo

// ---- ulsl_line_status.sv ----
// line status logic for one serial channel
// assumes sampler, transmit path and bus read strobe share clk_sys_i
//
// What this block does
// - bit 7 rises while any character in the receive fifo has an error tag.
// - bit 7 falls only once no remaining fifo character carries a tag.
// - without fifo, bit 6 is one when holding and shift registers are empty.
// - bit 6 goes to zero as soon as holding or shift register has data.
// - with fifo, bit 6 is one only when transmit fifo and shift are empty.
// - without fifo, bit 5 sets when a character moves holding to shift.
// - bit 5 clears two edges after the cycle that the cpu loads the holding register.
// - an interrupt is requested while the holding-empty flag and its enable are both set, one edge ahead of bit 5.
// - with fifo, bit 5 sets on transmit fifo empty, clears on a write.
// - bit 4 sets when the receive line stays low for a whole frame.
// - with fifo, each break condition stores exactly one break character.
// - bit 3 flags a missing stop bit, in fifo mode for the fifo top.
// - bit 2 flags bad parity, in fifo mode for the fifo top.
// - bit 1 flags overrun when a character meets a full fifo, dropping it.
// - bit 0 is one while any received character is held.
`timescale 1ns/1ps
`include "ulsl_map.svh"
module ulsl_line_status #(
   parameter int DEPTH = `ULSL_FIFO_DEPTH
) (
   // clock, reset, enable
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // mode and enables
   input wire logic fifo_mode_i,
   input wire logic hold_ie_i,
   // receive side
   input wire ulsl_pkg::ulsl_rx_evt_t rx_evt_i,
   input wire logic rx_line_i,
   input wire logic rx_pop_i,
   output logic rx_push_o,
   // transmit side
   input wire ulsl_pkg::ulsl_tx_stat_t tx_i,
   // cpu read port
   input wire logic status_rd_i,
   output logic [7:0] line_status_o,
   output logic hold_irq_o
);
   import ulsl_pkg::*;
   localparam int CW = $clog2(DEPTH) + 1;

   // refuse depths the tag store and its limit cannot hold
   if (DEPTH < 2 || DEPTH > 256
       || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("ulsl_line_status: DEPTH must be a power of two, 2 to 256");
   end

   // ****************************************************************
   // receive error tags and overrun
   // ****************************************************************
   ulsl_tag_t head;
   ulsl_tag_t new_tag;
   logic rx_empty;
   logic rx_full;
   logic err_any;
   logic brk_hold_reg;
   logic brk_dup;
   logic ovr_evt;
   logic mode_d_reg;
   logic [CW-1:0] limit;

   // holding-register mode is a store of depth one
   assign limit = fifo_mode_i ? CW'(DEPTH) : CW'(`ULSL_HOLD_DEPTH);
   assign new_tag = '{brk: rx_evt_i.all_low, frm: rx_evt_i.frm,
                      par: rx_evt_i.par};
   assign brk_dup = rx_evt_i.valid && rx_evt_i.all_low && brk_hold_reg;
   assign ovr_evt = rx_evt_i.valid && !brk_dup && rx_full;
   assign rx_push_o = rx_evt_i.valid && !brk_dup && !rx_full;

   ulsl_tag_fifo #(.DEPTH(DEPTH), .CW(CW)) u_tags (
      .clk_sys_i(clk_sys_i),
      .nrst_i(nrst_i),
      .ce_i(ce_i),
      .flush_i(fifo_mode_i != mode_d_reg),
      .limit_i(limit),
      .push_i(rx_push_o),
      .tag_i(new_tag),
      .pop_i(rx_pop_i),
      .head_o(head),
      .empty_o(rx_empty),
      .full_o(rx_full),
      .err_any_o(err_any)
   );

   // mode change flushes stale tags, as the data fifo is reset too
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i)
         mode_d_reg <= 1'b0;
      else if (ce_i)
         mode_d_reg <= fifo_mode_i;
   end

   // low frame marks break
   // held until the line returns high so a long break is one event
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i)
         brk_hold_reg <= 1'b0;
      else if (ce_i) begin
         if (rx_push_o && rx_evt_i.all_low)
            brk_hold_reg <= 1'b1;
         else if (rx_line_i)
            brk_hold_reg <= 1'b0;
      end
   end

   // ****************************************************************
   // sticky error flags
   // ****************************************************************
   logic ovr_reg;
   logic par_reg;
   logic frm_reg;
   logic brk_reg;

   // read clears flags
   // a new event in the read cycle wins over the clear
   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i) begin
         ovr_reg <= 1'b0;
         par_reg <= 1'b0;
         frm_reg <= 1'b0;
         brk_reg <= 1'b0;
      end else if (ce_i) begin
         ovr_reg <= ovr_evt || (ovr_reg && !status_rd_i);
         par_reg <= (rx_push_o && new_tag.par) || (par_reg && !status_rd_i);
         frm_reg <= (rx_push_o && new_tag.frm) || (frm_reg && !status_rd_i);
         brk_reg <= (rx_push_o && new_tag.brk) || (brk_reg && !status_rd_i);
      end
   end

   // ****************************************************************
   // transmit empty flags
   // ****************************************************************
   logic thre_reg;
   logic thre_next;
   logic tx_all_empty;

   // fifo empty sets flag
   // a load in the transfer cycle leaves a character, so clear wins
   always_comb begin
      thre_next = thre_reg;
      if (fifo_mode_i)
         thre_next = tx_i.fifo_empty && !tx_i.hold_write;
      else if (tx_i.hold_write)
         thre_next = 1'b0;
      else if (tx_i.hold_to_shift)
         thre_next = 1'b1;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i)
         thre_reg <= 1'b1;
      else if (ce_i)
         thre_reg <= thre_next;
   end

   assign tx_all_empty = thre_reg && !tx_i.shift_busy;

   assign hold_irq_o = thre_reg && hold_ie_i;

   // ****************************************************************
   // line_status word
   // ****************************************************************
   logic [7:0] status_next;

   // registered so the cpu sees a stable value through its read
   always_comb begin
      status_next = 8'h00;
      status_next[`ULSL_BIT_FIFO_ERR] = fifo_mode_i && err_any;
      status_next[`ULSL_BIT_TX_EMPTY] = tx_all_empty;
      status_next[`ULSL_BIT_HOLD_EMPTY] = thre_reg;
      if (fifo_mode_i) begin
         status_next[`ULSL_BIT_BREAK] = !rx_empty && head.brk;
         status_next[`ULSL_BIT_FRAMING] = !rx_empty && head.frm;
         status_next[`ULSL_BIT_PARITY] = !rx_empty && head.par;
      end else begin
         status_next[`ULSL_BIT_BREAK] = brk_reg;
         status_next[`ULSL_BIT_FRAMING] = frm_reg;
         status_next[`ULSL_BIT_PARITY] = par_reg;
      end
      status_next[`ULSL_BIT_OVERRUN] = ovr_reg;
      status_next[`ULSL_BIT_DATA_READY] = !rx_empty;
   end

   always_ff @(posedge clk_sys_i) begin
      if (!nrst_i)
         line_status_o <= `ULSL_RESET_VAL;
      else if (ce_i)
         line_status_o <= status_next;
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   sequence s_hold_load;
      ce_i && tx_i.hold_write;
   endsequence

   sequence s_overrun_seen;
      (ce_i && ovr_evt) ##1 ce_i;
   endsequence

   a_fifo_err_bit: assert property (@(posedge clk_sys_i)
      disable iff (!nrst_i)
      ce_i |=> line_status_o[7] == $past(fifo_mode_i && err_any))
      else $error("fifo error bit does not follow tagged count");

   a_tx_empty_clear: assert property (@(posedge clk_sys_i)
      disable iff (!nrst_i)
      ce_i && tx_i.shift_busy |=> !line_status_o[6])
      else $error("transmitter empty shown with busy shift register");

   a_tx_empty_set: assert property (@(posedge clk_sys_i)
      disable iff (!nrst_i)
      ce_i && thre_reg && !tx_i.shift_busy |=> line_status_o[6])
      else $error("transmitter empty not shown");

   a_hold_load_clear: assert property (@(posedge clk_sys_i)
      disable iff (!nrst_i)
      s_hold_load |=> !thre_reg ##1 (!$past(ce_i) || !line_status_o[5]))
      else $error("holding empty survives a load");

   a_hold_move_set: assert property (@(posedge clk_sys_i)
      disable iff (!nrst_i)
      ce_i && !fifo_mode_i && tx_i.hold_to_shift && !tx_i.hold_write
         |=> thre_reg)
      else $error("transfer did not set holding empty");

   // word bit 5 lags the flag by one enabled edge, so compare when stable
   a_hold_irq_req: assert property (@(posedge clk_sys_i)
      disable iff (!nrst_i)
      ce_i ##1 $stable(thre_reg)
         |-> hold_irq_o == (hold_ie_i && line_status_o[5]))
      else $error("interrupt does not follow holding empty and enable");

   a_break_single: assert property (@(posedge clk_sys_i)
      disable iff (!nrst_i)
      ce_i && rx_push_o && rx_evt_i.all_low ##1
         (!rx_line_i)[*1] |-> !(rx_evt_i.valid && rx_evt_i.all_low
         && rx_push_o))
      else $error("second break character stored for one break");

   a_overrun_flag: assert property (@(posedge clk_sys_i)
      disable iff (!nrst_i)
      s_overrun_seen |=> line_status_o[1])
      else $error("overrun not reported");

   a_overrun_drop: assert property (@(posedge clk_sys_i)
      disable iff (!nrst_i)
      ovr_evt |-> !rx_push_o)
      else $error("overrun character entered the fifo");

   a_read_clear: assert property (@(posedge clk_sys_i)
      disable iff (!nrst_i)
      ce_i && status_rd_i && !ovr_evt |=> !ovr_reg)
      else $error("read did not clear overrun");

   a_data_ready: assert property (@(posedge clk_sys_i)
      disable iff (!nrst_i)
      ce_i |=> line_status_o[0] == $past(!rx_empty))
      else $error("data ready does not track held characters");

   a_top_tags: assert property (@(posedge clk_sys_i)
      disable iff (!nrst_i)
      ce_i && fifo_mode_i && !rx_empty
         |=> line_status_o[3:2] == $past({head.frm, head.par}))
      else $error("error bits do not show the fifo top");
endmodule : ulsl_line_status

// ---- ulsl_host_model.sv ----
// host-side model: drives receive, transmit and read inputs of the block
// assumes one caller thread; every task starts and ends just after an edge
`timescale 1ns/1ps
module ulsl_host_model
   import ulsl_pkg::*;
(
   // clock
   input wire logic clk_sys_i,
   // stimulus towards the block
   output ulsl_pkg::ulsl_rx_evt_t rx_evt_o,
   output ulsl_pkg::ulsl_tx_stat_t tx_o,
   output logic rx_line_o,
   output logic rx_pop_o,
   output logic status_rd_o,
   // observed from the block
   input wire logic rx_push_i,
   input wire logic [7:0] line_status_i
);
   // ****************************************
   // idle levels and access tasks
   // ****************************************
   // line idles at mark, transmit side empty
   initial begin
      rx_evt_o = '0;
      tx_o = 4'h1;
      rx_line_o = 1'b1;
      rx_pop_o = 1'b0;
      status_rd_o = 1'b0;
   end
   // three edges cover the two-edge status latency
   task automatic settle();
      repeat (3) @(posedge clk_sys_i);
   endtask : settle
   // read strobe, word sampled mid-cycle where it is settled
   task automatic read_status(output logic [7:0] val);
      @(posedge clk_sys_i);
      status_rd_o <= 1'b1;
      @(negedge clk_sys_i);
      val = line_status_i;
      @(posedge clk_sys_i);
      status_rd_o <= 1'b0;
      settle();
   endtask : read_status
   // one finished character with its tags
   task automatic send_char(input logic b, input logic f, input logic p,
                            output logic pushed);
      @(posedge clk_sys_i);
      rx_evt_o <= {1'b1, b, f, p};
      @(negedge clk_sys_i);
      pushed = rx_push_i;
      @(posedge clk_sys_i);
      rx_evt_o <= '0;
      settle();
   endtask : send_char
   task automatic pop_char();
      @(posedge clk_sys_i);
      rx_pop_o <= 1'b1;
      @(posedge clk_sys_i);
      rx_pop_o <= 1'b0;
      settle();
   endtask : pop_char
   // transmit pulses: load and move to shift register
   task automatic tx_pulse(input logic wr, input logic mv);
      @(posedge clk_sys_i);
      tx_o.hold_write <= wr;
      tx_o.hold_to_shift <= mv;
      @(posedge clk_sys_i);
      tx_o.hold_write <= 1'b0;
      tx_o.hold_to_shift <= 1'b0;
      settle();
   endtask : tx_pulse
   task automatic tx_level(input logic busy, input logic empty);
      @(posedge clk_sys_i);
      tx_o.shift_busy <= busy;
      tx_o.fifo_empty <= empty;
      settle();
   endtask : tx_level
   task automatic set_line(input logic lvl);
      @(posedge clk_sys_i);
      rx_line_o <= lvl;
      settle();
   endtask : set_line
endmodule : ulsl_host_model

// ---- tb.sv ----
// self-checking bench for the line status logic
// assumes the host model drives all traffic; fifo depth shrunk to 4
`timescale 1ns/1ps
module tb;
   import ulsl_pkg::*;
   // ****************************************
   // signals, clock, instances
   // ****************************************
   localparam int DEPTH_T = 4;
   logic clk_sys_i, nrst_i, fifo_mode_i, hold_ie_i, ce;
   ulsl_rx_evt_t rx_evt;
   ulsl_tx_stat_t tx_stat;
   logic rx_line, rx_pop, status_rd, rx_push, hold_irq, pp;
   logic [7:0] line_status, v;
   int err_count = 0;
   int check_count = 0;
   int cycles = 0;
   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end
   ulsl_line_status #(.DEPTH(DEPTH_T)) ulsl_line_status_i (
      .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .ce_i(ce),
      .fifo_mode_i(fifo_mode_i), .hold_ie_i(hold_ie_i),
      .rx_evt_i(rx_evt), .rx_line_i(rx_line), .rx_pop_i(rx_pop),
      .rx_push_o(rx_push), .tx_i(tx_stat), .status_rd_i(status_rd),
      .line_status_o(line_status), .hold_irq_o(hold_irq));
   ulsl_host_model ulsl_host_model_i (
      .clk_sys_i(clk_sys_i), .rx_evt_o(rx_evt), .tx_o(tx_stat),
      .rx_line_o(rx_line), .rx_pop_o(rx_pop), .status_rd_o(status_rd),
      .rx_push_i(rx_push), .line_status_i(line_status));
   // ****************************************
   // compare and verdict tasks
   // ****************************************
   task automatic check_word(input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : check_word
   task automatic check_bit(input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("BAD t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : check_bit
   task automatic print_verdict();
      if (err_count == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict
   task automatic rd(input logic [7:0] e);
      ulsl_host_model_i.read_status(v);
      check_word(e, v);
   endtask : rd
   task automatic send(input logic b, f, p, input logic push_exp);
      ulsl_host_model_i.send_char(b, f, p, pp);
      check_bit(push_exp, pp);
   endtask : send
   task automatic irq_is(input logic e);
      @(negedge clk_sys_i);
      check_bit(e, hold_irq);
   endtask : irq_is
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge clk_sys_i) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         print_verdict();
      end
   end
   // ****************************************
   // main sequence
   // ****************************************
   initial begin
      nrst_i = 1'b0;
      fifo_mode_i = 1'b0;
      hold_ie_i = 1'b1;
      ce = 1'b1;
      repeat (8) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      rd(8'h60);
      irq_is(1'b1);
      @(posedge clk_sys_i);
      hold_ie_i <= 1'b0;
      irq_is(1'b0);
      @(posedge clk_sys_i);
      hold_ie_i <= 1'b1;
      // holding-register mode transmit flags
      ulsl_host_model_i.tx_pulse(1'b1, 1'b0);
      rd(8'h00);
      irq_is(1'b0);
      ulsl_host_model_i.tx_level(1'b1, 1'b1);
      ulsl_host_model_i.tx_pulse(1'b0, 1'b1);
      rd(8'h20);
      irq_is(1'b1);
      ulsl_host_model_i.tx_level(1'b0, 1'b1);
      rd(8'h60);
      // receive errors, sticky until read
      send(1'b0, 1'b0, 1'b1, 1'b1);
      rd(8'h65);
      rd(8'h61);
      send(1'b0, 1'b0, 1'b0, 1'b0);
      rd(8'h63);
      rd(8'h61);
      ulsl_host_model_i.pop_char();
      rd(8'h60);
      send(1'b0, 1'b1, 1'b0, 1'b1);
      rd(8'h69);
      ulsl_host_model_i.pop_char();
      rd(8'h60);
      // one break character per low period
      ulsl_host_model_i.set_line(1'b0);
      send(1'b1, 1'b0, 1'b0, 1'b1);
      rd(8'h71);
      ulsl_host_model_i.pop_char();
      send(1'b1, 1'b0, 1'b0, 1'b0);
      rd(8'h60);
      ulsl_host_model_i.set_line(1'b1);
      // fifo mode transmit flags
      @(posedge clk_sys_i);
      fifo_mode_i <= 1'b1;
      ulsl_host_model_i.tx_level(1'b0, 1'b0);
      rd(8'h00);
      ulsl_host_model_i.tx_level(1'b1, 1'b1);
      rd(8'h20);
      ulsl_host_model_i.tx_level(1'b0, 1'b1);
      rd(8'h60);
      // error tag anywhere in fifo, flags of the top
      send(1'b0, 1'b0, 1'b0, 1'b1);
      send(1'b0, 1'b0, 1'b1, 1'b1);
      rd(8'hE1);
      ulsl_host_model_i.pop_char();
      rd(8'hE5);
      send(1'b0, 1'b0, 1'b0, 1'b1);
      ulsl_host_model_i.pop_char();
      rd(8'h61);
      ulsl_host_model_i.pop_char();
      rd(8'h60);
      // break in fifo mode
      ulsl_host_model_i.set_line(1'b0);
      send(1'b1, 1'b0, 1'b0, 1'b1);
      send(1'b1, 1'b0, 1'b0, 1'b0);
      rd(8'hF1);
      ulsl_host_model_i.set_line(1'b1);
      ulsl_host_model_i.pop_char();
      rd(8'h60);
      // fill to the limit, then one more overruns
      for (int i = 0; i < DEPTH_T; i++) send(1'b0, 1'b0, 1'b0, 1'b1);
      send(1'b0, 1'b0, 1'b0, 1'b0);
      // frozen enable: word held, the read strobe clears nothing
      @(posedge clk_sys_i);
      ce <= 1'b0;
      rd(8'h63);
      ce <= 1'b1;
      rd(8'h63);
      rd(8'h61);
      for (int i = 0; i < DEPTH_T; i++) ulsl_host_model_i.pop_char();
      rd(8'h60);
      // mid-run reset drops the stored character and its tags
      send(1'b0, 1'b1, 1'b0, 1'b1);
      @(posedge clk_sys_i);
      nrst_i <= 1'b0;
      repeat (2) @(posedge clk_sys_i);
      nrst_i <= 1'b1;
      rd(8'h60);
      print_verdict();
   end
endmodule : tb
